// File: design/bwc_defs.svh
// constants for the battery wake control block
`ifndef BWC_DEFS_SVH
`define BWC_DEFS_SVH

`define BWC_NWAKE 7
`define BWC_CLK_NS 100
`define BWC_FILT_NS 1000
`define BWC_FILT_CYC ((`BWC_FILT_NS + `BWC_CLK_NS - 1) / `BWC_CLK_NS)
`define BWC_FILT_W 4
`define BWC_SLOW_HZ 32768
`define BWC_STEP_HZ 8
`define BWC_SLOW_PER_STEP (`BWC_SLOW_HZ / `BWC_STEP_HZ)
`define BWC_PRESC_W 12

`define BWC_OFS_CTRL 8'h00
`define BWC_OFS_LATCH_EN 8'h04
`define BWC_OFS_LATCH_RST 8'h08
`define BWC_OFS_IN_EN 8'h0c
`define BWC_OFS_HOLDOFF 8'h10
`define BWC_OFS_POL 8'h14
`define BWC_OFS_POSEDGE 8'h18
`define BWC_OFS_NEGEDGE 8'h1c
`define BWC_OFS_BUF_EN 8'h20

`define BWC_BIT_OUT 9
`define BWC_BIT_FW_LVL 10
`define BWC_BIT_FW_SEL 11
`define BWC_BIT_BYPASS 12
`define BWC_BIT_HOLDOFF 13
`define BWC_BIT_PIN_SEL 7
`define BWC_BIT_WEEK 16
`define BWC_BIT_CAL 17

`define BWC_RST_IN_EN 7'h07
`define BWC_RST_LATCH_EN 7'h30
`define BWC_RST_POL 7'h00
`define BWC_RST_BUF_EN 7'h00
`define BWC_RST_HOLDOFF 8'h00
`define BWC_RST_PIN_SEL 1'h1

`endif

// File: design/bwc_pkg.sv
// types of the battery wake control block
`include "bwc_defs.svh"
package bwc_pkg;

typedef enum logic {
    BWC_HO_IDLE,
    BWC_HO_RUN
} bwc_ho_state_t;

typedef struct packed {
    logic level;
    logic [`BWC_FILT_W-1:0] cnt;
    logic latch;
    logic pos;
    logic neg;
} bwc_chan_state_t;

typedef struct packed {
    logic [`BWC_NWAKE-1:0] wk1;
    logic [`BWC_NWAKE-1:0] wk2;
    logic [2:0] week_s;
    logic [2:0] cal_s;
    logic [1:0] pg_s;
    logic [2:0] sd_s;
    logic [2:0] slow_s;
    logic [`BWC_NWAKE-1:0] latch_en;
    logic [`BWC_NWAKE-1:0] in_en;
    logic [`BWC_NWAKE-1:0] pol;
    logic [`BWC_NWAKE-1:0] buf_en;
    logic bypass;
    logic fw_sel;
    logic fw_lvl;
    logic pin_sel;
    logic week_le;
    logic cal_le;
    logic week_lat;
    logic cal_lat;
    logic [7:0] holdoff;
    bwc_ho_state_t ho_state;
    logic [7:0] ho_left;
    logic [`BWC_PRESC_W-1:0] presc;
    logic out;
    logic [`BWC_NWAKE-1:0] irq;
    logic pin_wake;
    logic ack;
    logic [31:0] dat;
} bwc_state_t;

endpackage

// File: design/bwc_chan_if.sv
// carrier between the top and one wake input channel
`timescale 1ns/10ps
interface bwc_chan_if;
    logic pin;
    logic bypass;
    logic buf_en;
    logic pol;
    logic latch_en;
    logic latch_rst;
    logic pos_clr;
    logic neg_clr;
    logic status;
    logic pos;
    logic neg;

    modport chan (
        input pin, bypass, buf_en, pol, latch_en, latch_rst, pos_clr, neg_clr,
        output status, pos, neg
    );
    modport ctrl (
        output pin, bypass, buf_en, pol, latch_en, latch_rst, pos_clr, neg_clr,
        input status, pos, neg
    );
endinterface

// File: design/bwc_wake_chan.sv
// one wake input: filter, polarity, latch and edge status
`timescale 1ns/10ps
`include "bwc_defs.svh"
module bwc_wake_chan
    import bwc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    bwc_chan_if.chan ch
);
    bwc_chan_state_t s_q;
    bwc_chan_state_t s_d;
    logic active;

    always_comb begin
        s_d = s_q;
        // a disabled buffer freezes the path, so its edges are lost
        if (ch.buf_en) begin
            if (ch.bypass) begin
                s_d.level = ch.pin;
                s_d.cnt = '0;
            end else if (ch.pin != s_q.level) begin
                s_d.cnt = s_q.cnt + `BWC_FILT_W'(1);
                if (s_q.cnt == `BWC_FILT_W'(`BWC_FILT_CYC - 1)) begin
                    s_d.level = ch.pin;
                    s_d.cnt = '0;
                end
            end else begin
                s_d.cnt = '0;
            end
        end
        // edges seen on the filtered pin, before inversion
        if (ch.pos_clr) begin
            s_d.pos = 1'b0;
        end
        if (ch.neg_clr) begin
            s_d.neg = 1'b0;
        end
        if (ch.buf_en && !s_q.level && s_d.level) begin
            s_d.pos = 1'b1;
        end
        if (ch.buf_en && s_q.level && !s_d.level) begin
            s_d.neg = 1'b1;
        end
        // active low unless inverted; pin asserted beats latch reset
        active = ch.pol ? s_d.level : ~s_d.level;
        if (ch.latch_rst) begin
            s_d.latch = 1'b0;
        end
        if (ch.latch_en && ch.buf_en && active) begin
            s_d.latch = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '{level: 1'b1, cnt: '0, latch: 1'b0, pos: 1'b0,
                     neg: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // status shows the latch when latching, else the live level
    assign ch.status = ch.latch_en ? s_q.latch
                     : (ch.buf_en & (ch.pol ? s_q.level : ~s_q.level));
    assign ch.pos = s_q.pos;
    assign ch.neg = s_q.neg;
endmodule

// File: design/bwc_top.sv
// battery wake control: wake inputs, alarms, holdoff and bus slave
`timescale 1ns/10ps
`include "bwc_defs.svh"

// How it works
// - hardware ORs enabled wakes and both alarms
// - inputs active low, per-input polarity inversion
// - input enable gates each wake onto output
// - input state readable even when not enabled
// - glitch filter per input, one bypass bit
// - optional latch holds assertion after pin releases
// - both enables zero fully disables input
// - rail up and select set: output follows level
// - rail down: output from hardware logic
// - inversion after filter, before status latch
// - edge detect on filtered, uninverted level, any polarity
// - separate rising and falling edge status bits
// - edges only while the input buffer enabled
// - wake interrupts only while main rail up
// - battery reset loads all defaults, system reset isolates
// - rail down forces pins to wake function
// - holdoff forces hardware request low; firmware select with rail up still drives output
// - zero holdoff count disables timer entirely
// - holdoff asserts within one slow clock cycle
// - prescaler makes 8 Hz, 125 ms steps
// - no low power modes, always running
// - seven wake inputs, unused tied inactive
// - latch reset loses to an asserted input
// - count 1 to 255 gives 125 ms steps
module bwc_top
    import bwc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic system_domain_reset_i,
    input wire logic [`BWC_NWAKE-1:0] wake_input_n_i,
    input wire logic week_alarm_i,
    input wire logic cal_alarm_i,
    input wire logic main_rail_good_i,
    input wire logic shutdown_in_n_i,
    input wire logic slow_clk_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic power_request_out_o,
    output logic [`BWC_NWAKE-1:0] wake_irq_o,
    output logic pin_is_wake_o,
    output logic holdoff_o
);
    bwc_state_t s_q;
    bwc_state_t s_d;

    bwc_chan_if ch_if [`BWC_NWAKE] ();
    logic [`BWC_NWAKE-1:0] st;
    logic [`BWC_NWAKE-1:0] pos;
    logic [`BWC_NWAKE-1:0] neg;
    logic [`BWC_NWAKE-1:0] ls_pulse;
    logic [`BWC_NWAKE-1:0] pos_clr;
    logic [`BWC_NWAKE-1:0] neg_clr;

    genvar g;
    generate
        for (g = 0; g < `BWC_NWAKE; g++) begin : gen_chan
            assign ch_if[g].pin = s_q.wk2[g];
            assign ch_if[g].bypass = s_q.bypass;
            assign ch_if[g].buf_en = s_q.in_en[g] | s_q.buf_en[g];
            assign ch_if[g].pol = s_q.pol[g];
            assign ch_if[g].latch_en = s_q.latch_en[g];
            assign ch_if[g].latch_rst = ls_pulse[g];
            assign ch_if[g].pos_clr = pos_clr[g];
            assign ch_if[g].neg_clr = neg_clr[g];
            assign st[g] = ch_if[g].status;
            assign pos[g] = ch_if[g].pos;
            assign neg[g] = ch_if[g].neg;
            bwc_wake_chan u_chan (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .ch(ch_if[g].chan)
            );
        end
    endgenerate

    // merge write data into an old word under the byte lanes
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0] sel
    );
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    logic req;
    logic wr;
    logic [31:0] wmask;
    logic [31:0] ctrl_rd;
    logic [31:0] rd;
    logic [31:0] wv;
    logic rail_good;
    logic sd_fall;
    logic slow_rise;
    logic step;
    logic week_act;
    logic cal_act;
    logic hw_req;
    logic ho_active;

    always_comb begin
        s_d = s_q;
        rd = '0;
        wv = '0;
        ls_pulse = '0;
        pos_clr = '0;
        neg_clr = '0;

        // two flops on wake pins and rail, three on alarms, shutdown and slow clock
        s_d.wk1 = wake_input_n_i;
        s_d.wk2 = s_q.wk1;
        s_d.week_s = {s_q.week_s[1:0], week_alarm_i};
        s_d.cal_s = {s_q.cal_s[1:0], cal_alarm_i};
        s_d.pg_s = {s_q.pg_s[0], main_rail_good_i};
        s_d.sd_s = {s_q.sd_s[1:0], shutdown_in_n_i};
        s_d.slow_s = {s_q.slow_s[1:0], slow_clk_i};
        rail_good = s_q.pg_s[1];
        sd_fall = s_q.sd_s[2] & ~s_q.sd_s[1];
        slow_rise = s_q.slow_s[1] & ~s_q.slow_s[2];

        // system reset only isolates the bus side
        req = wb_cyc_i & wb_stb_i & ~s_q.ack & ~system_domain_reset_i;
        // a write lands on the edge where the master sees ack
        wr = wb_cyc_i & wb_stb_i & wb_we_i & s_q.ack & ~system_domain_reset_i;
        wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                 {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

        ctrl_rd = '0;
        ctrl_rd[`BWC_NWAKE-1:0] = st;
        ctrl_rd[`BWC_BIT_PIN_SEL] = s_q.pin_sel;
        ctrl_rd[`BWC_BIT_OUT] = s_q.out;
        ctrl_rd[`BWC_BIT_FW_LVL] = s_q.fw_lvl;
        ctrl_rd[`BWC_BIT_FW_SEL] = s_q.fw_sel;
        ctrl_rd[`BWC_BIT_BYPASS] = s_q.bypass;
        ctrl_rd[`BWC_BIT_HOLDOFF] = (s_q.ho_state == BWC_HO_RUN);
        ctrl_rd[`BWC_BIT_WEEK] = s_q.week_le ? s_q.week_lat : s_q.week_s[2];
        ctrl_rd[`BWC_BIT_CAL] = s_q.cal_le ? s_q.cal_lat : s_q.cal_s[2];

        case (wb_adr_i)
            `BWC_OFS_CTRL: begin
                rd = ctrl_rd;
            end
            `BWC_OFS_LATCH_EN: begin
                rd[`BWC_NWAKE-1:0] = s_q.latch_en;
                rd[`BWC_BIT_WEEK] = s_q.week_le;
                rd[`BWC_BIT_CAL] = s_q.cal_le;
            end
            `BWC_OFS_IN_EN: begin
                rd[`BWC_NWAKE-1:0] = s_q.in_en;
            end
            `BWC_OFS_HOLDOFF: begin
                rd[7:0] = s_q.holdoff;
            end
            `BWC_OFS_POL: begin
                rd[`BWC_NWAKE-1:0] = s_q.pol;
            end
            `BWC_OFS_POSEDGE: begin
                rd[`BWC_NWAKE-1:0] = pos;
            end
            `BWC_OFS_NEGEDGE: begin
                rd[`BWC_NWAKE-1:0] = neg;
            end
            `BWC_OFS_BUF_EN: begin
                rd[`BWC_NWAKE-1:0] = s_q.buf_en;
            end
            default: begin
                rd = '0;
            end
        endcase

        if (wr) begin
            case (wb_adr_i)
                `BWC_OFS_CTRL: begin
                    wv = merge(ctrl_rd, wb_dat_i, wb_sel_i);
                    s_d.pin_sel = wv[`BWC_BIT_PIN_SEL];
                    s_d.fw_lvl = wv[`BWC_BIT_FW_LVL];
                    s_d.fw_sel = wv[`BWC_BIT_FW_SEL];
                    s_d.bypass = wv[`BWC_BIT_BYPASS];
                end
                `BWC_OFS_LATCH_EN: begin
                    wv = merge(rd, wb_dat_i, wb_sel_i);
                    s_d.latch_en = wv[`BWC_NWAKE-1:0];
                    s_d.week_le = wv[`BWC_BIT_WEEK];
                    s_d.cal_le = wv[`BWC_BIT_CAL];
                end
                `BWC_OFS_LATCH_RST: begin
                    wv = wb_dat_i & wmask;
                    ls_pulse = wv[`BWC_NWAKE-1:0];
                    if (wv[`BWC_BIT_WEEK]) begin
                        s_d.week_lat = 1'b0;
                    end
                    if (wv[`BWC_BIT_CAL]) begin
                        s_d.cal_lat = 1'b0;
                    end
                end
                `BWC_OFS_IN_EN: begin
                    wv = merge(rd, wb_dat_i, wb_sel_i);
                    s_d.in_en = wv[`BWC_NWAKE-1:0];
                end
                `BWC_OFS_HOLDOFF: begin
                    wv = merge(rd, wb_dat_i, wb_sel_i);
                    s_d.holdoff = wv[7:0];
                end
                `BWC_OFS_POL: begin
                    wv = merge(rd, wb_dat_i, wb_sel_i);
                    s_d.pol = wv[`BWC_NWAKE-1:0];
                end
                `BWC_OFS_POSEDGE: begin
                    wv = wb_dat_i & wmask;
                    pos_clr = wv[`BWC_NWAKE-1:0];
                end
                `BWC_OFS_NEGEDGE: begin
                    wv = wb_dat_i & wmask;
                    neg_clr = wv[`BWC_NWAKE-1:0];
                end
                `BWC_OFS_BUF_EN: begin
                    wv = merge(rd, wb_dat_i, wb_sel_i);
                    s_d.buf_en = wv[`BWC_NWAKE-1:0];
                end
                default: begin
                    wv = '0;
                end
            endcase
        end

        // alarm latches: a live alarm beats its reset
        if (s_q.week_le && s_q.week_s[2]) begin
            s_d.week_lat = 1'b1;
        end
        if (s_q.cal_le && s_q.cal_s[2]) begin
            s_d.cal_lat = 1'b1;
        end
        week_act = s_q.week_le ? s_q.week_lat : s_q.week_s[2];
        cal_act = s_q.cal_le ? s_q.cal_lat : s_q.cal_s[2];

        // inhibit timer, stepped by 8 Hz from the slow clock
        step = 1'b0;
        if (slow_rise) begin
            if (s_q.presc == `BWC_PRESC_W'(`BWC_SLOW_PER_STEP - 1)) begin
                s_d.presc = '0;
                step = 1'b1;
            end else begin
                s_d.presc = s_q.presc + `BWC_PRESC_W'(1);
            end
        end
        case (s_q.ho_state)
            BWC_HO_IDLE: begin
                if (sd_fall && s_q.holdoff != 8'h00) begin
                    s_d.ho_state = BWC_HO_RUN;
                    s_d.ho_left = s_q.holdoff;
                    s_d.presc = '0;
                end
            end
            BWC_HO_RUN: begin
                if (s_q.holdoff == 8'h00) begin
                    s_d.ho_state = BWC_HO_IDLE;
                    s_d.ho_left = 8'h00;
                end else if (sd_fall) begin
                    s_d.ho_left = s_q.holdoff;
                    s_d.presc = '0;
                end else if (step) begin
                    s_d.ho_left = s_q.ho_left - 8'h01;
                    if (s_q.ho_left == 8'h01) begin
                        s_d.ho_state = BWC_HO_IDLE;
                    end
                end
            end
            default: begin
                s_d.ho_state = BWC_HO_IDLE;
            end
        endcase
        ho_active = (s_d.ho_state == BWC_HO_RUN);

        // the inhibit overrides every hardware source
        hw_req = ~ho_active & (|(st & s_q.in_en) | week_act | cal_act);
        if (rail_good && s_q.fw_sel) begin
            s_d.out = s_q.fw_lvl;
        end else begin
            s_d.out = hw_req;
        end
        s_d.irq = rail_good ? st : '0;
        s_d.pin_wake = ~rail_good | s_q.pin_sel;

        s_d.ack = req;
        s_d.dat = req ? rd : '0;
    end

    // no sleep state: the whole block runs on every edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.wk1 <= '1;
            s_q.wk2 <= '1;
            s_q.sd_s <= 3'h7;
            s_q.latch_en <= `BWC_RST_LATCH_EN;
            s_q.in_en <= `BWC_RST_IN_EN;
            s_q.pol <= `BWC_RST_POL;
            s_q.buf_en <= `BWC_RST_BUF_EN;
            s_q.holdoff <= `BWC_RST_HOLDOFF;
            s_q.pin_sel <= `BWC_RST_PIN_SEL;
            s_q.pin_wake <= 1'b1;
            s_q.ho_state <= BWC_HO_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_dat_o = s_q.dat;
    assign wb_ack_o = s_q.ack;
    assign power_request_out_o = s_q.out;
    assign wake_irq_o = s_q.irq;
    assign pin_is_wake_o = s_q.pin_wake;
    assign holdoff_o = (s_q.ho_state == BWC_HO_RUN);
endmodule

// File: verif/bwc_top_chk.sv
// assertions on the battery wake control top ports
`timescale 1ns/10ps
`include "bwc_defs.svh"
module bwc_top_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic system_domain_reset_i,
    input wire logic main_rail_good_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic power_request_out_o,
    input wire logic [`BWC_NWAKE-1:0] wake_irq_o,
    input wire logic pin_is_wake_o,
    input wire logic holdoff_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o &&
        !system_domain_reset_i |=> wb_ack_o)
        else $error("ack not one cycle after request");
    chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    chk_sys_block: assert property (
        system_domain_reset_i |=> !wb_ack_o)
        else $error("ack during system reset");
    chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    chk_holdoff_out: assert property (
        holdoff_o [*3] |-> !power_request_out_o)
        else $error("power request during holdoff");
    chk_irq_rail: assert property (
        !main_rail_good_i [*4] |-> wake_irq_o == '0)
        else $error("wake interrupt with rail down");
    chk_pin_rail: assert property (
        !main_rail_good_i [*4] |-> pin_is_wake_o)
        else $error("shared pin not in wake function");
    chk_reset_vals: assert property (disable iff (1'b0)
        rst_i |=> !power_request_out_o && !holdoff_o && pin_is_wake_o &&
        !wb_ack_o && wake_irq_o == '0)
        else $error("outputs wrong in battery reset");
endmodule

bind bwc_top bwc_top_chk u_chk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .system_domain_reset_i(system_domain_reset_i),
    .main_rail_good_i(main_rail_good_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .power_request_out_o(power_request_out_o),
    .wake_irq_o(wake_irq_o),
    .pin_is_wake_o(pin_is_wake_o),
    .holdoff_o(holdoff_o)
);

// File: verif/bwc_far_side.sv
// far side model: wake pins, alarms, main rail, shutdown and slow clock
`timescale 1ns/10ps
`include "bwc_defs.svh"
module bwc_far_side (
    input wire logic clk_i,
    input wire logic [`BWC_NWAKE-1:0] pin_lvl_i,
    input wire logic week_i,
    input wire logic cal_i,
    input wire logic rail_i,
    input wire logic shut_i,
    output logic [`BWC_NWAKE-1:0] wake_input_n_o,
    output logic week_alarm_o,
    output logic cal_alarm_o,
    output logic main_rail_good_o,
    output logic shutdown_in_n_o,
    output logic slow_clk_o
);
    // every pin routed here; an unrouted one would sit high
    assign wake_input_n_o = pin_lvl_i;
    assign week_alarm_o = week_i;
    assign cal_alarm_o = cal_i;
    assign main_rail_good_o = rail_i;
    assign shutdown_in_n_o = ~shut_i;
    // crystal runs free; sped up to 4 fast cycles to keep runs short
    initial begin
        slow_clk_o = 1'b0;
        forever begin
            repeat (2) @(posedge clk_i);
            slow_clk_o <= ~slow_clk_o;
        end
    end
endmodule

// File: verif/tb.sv
// self-checking bench for the battery wake control block
`timescale 1ns/10ps
`include "bwc_defs.svh"
module tb;
    localparam int ho_cyc = `BWC_SLOW_PER_STEP * 4;
    logic clk_i, rst_i, sys_rst, cyc, stb, we, ack, out, hold, pwake, g;
    logic week, cal, rail, shut, week_p, cal_p, rail_p, shut_n, slow;
    logic [7:0] adr;
    logic [31:0] wdat, rdat, q;
    logic [`BWC_NWAKE-1:0] lvl, pins_n, irq;
    logic [7:0] ra[9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
        8'h18, 8'h1c, 8'h40};
    logic [31:0] rv[9] = '{32'h80, 32'h30, 0, 32'h07, 0, 0, 0, 0, 0};
    int fails, n_checks, cyc_cnt, n;
    bwc_far_side u_far (.clk_i(clk_i), .pin_lvl_i(lvl), .week_i(week),
        .cal_i(cal), .rail_i(rail), .shut_i(shut), .wake_input_n_o(pins_n),
        .week_alarm_o(week_p), .cal_alarm_o(cal_p),
        .main_rail_good_o(rail_p), .shutdown_in_n_o(shut_n),
        .slow_clk_o(slow));
    bwc_top dut (.clk_i(clk_i), .rst_i(rst_i),
        .system_domain_reset_i(sys_rst), .wake_input_n_i(pins_n),
        .week_alarm_i(week_p), .cal_alarm_i(cal_p),
        .main_rail_good_i(rail_p), .shutdown_in_n_i(shut_n),
        .slow_clk_i(slow), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .power_request_out_o(out), .wake_irq_o(irq),
        .pin_is_wake_o(pwake), .holdoff_o(hold));
    task automatic report_and_stop;
        if (fails == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] e,
        input logic [31:0] v);
        n_checks++;
        if (v !== e) begin
            fails++;
            $display("wrong value %s exp %h got %h", nm, e, v);
        end
    endtask
    // no cycle count assumed; give up after 8 edges
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 8);
        g = ack;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        check("write ack", 1, g);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 0);
        check("read ack", 1, g);
        check($sformatf("reg %h", a), e, q);
    endtask
    task automatic settle(input int c);
        repeat (c) @(posedge clk_i);
    endtask
    task automatic wait_out(input logic e);
        int k;
        k = 0;
        while (out !== e && k < 20) begin
            @(posedge clk_i);
            k++;
        end
        check("power request", e, out);
    endtask
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 60000) begin
            fails++;
            report_and_stop();
        end
    end
    initial begin
        {rst_i, sys_rst, cyc, stb, we, adr, wdat} = '0;
        rst_i = 1'b1;
        lvl = '1;
        {week, cal, shut, fails, n_checks, cyc_cnt} = '0;
        rail = 1'b1;
        settle(4);
        rst_i <= 1'b0;
        for (int i = 0; i < 9; i++) rd(ra[i], rv[i]);
        lvl[0] <= 1'b0;
        settle(4);
        lvl[0] <= 1'b1;
        settle(30);
        check("short glitch", 0, out);
        lvl[0] <= 1'b0;
        settle(20);
        wait_out(1'b1);
        lvl[0] <= 1'b1;
        settle(20);
        wait_out(1'b0);
        wr(8'h00, 32'h1080);
        wr(8'h18, 32'h7f);
        wr(8'h1c, 32'h7f);
        wr(8'h20, 32'h08);
        lvl[3] <= 1'b0;
        settle(20);
        check("unenabled input", 0, out);
        rd(8'h00, 32'h1088);
        rd(8'h1c, 32'h08);
        lvl[3] <= 1'b1;
        settle(10);
        rd(8'h18, 32'h08);
        wr(8'h18, 32'h08);
        rd(8'h18, 32'h00);
        wr(8'h1c, 32'h08);
        rd(8'h1c, 32'h00);
        lvl[6] <= 1'b0;
        settle(10);
        lvl[6] <= 1'b1;
        settle(10);
        rd(8'h1c, 32'h00);
        rd(8'h18, 32'h00);
        wr(8'h14, 32'h02);
        wait_out(1'b1);
        rd(8'h00, 32'h1282);
        wr(8'h14, 32'h00);
        wait_out(1'b0);
        wr(8'h04, 32'h04);
        lvl[2] <= 1'b0;
        settle(10);
        lvl[2] <= 1'b1;
        settle(10);
        check("latched request", 1, out);
        lvl[2] <= 1'b0;
        settle(10);
        wr(8'h08, 32'h04);
        rd(8'h00, 32'h1284);
        lvl[2] <= 1'b1;
        settle(10);
        wr(8'h08, 32'h04);
        settle(4);
        rd(8'h00, 32'h1080);
        week <= 1'b1;
        wait_out(1'b1);
        week <= 1'b0;
        wait_out(1'b0);
        cal <= 1'b1;
        wait_out(1'b1);
        cal <= 1'b0;
        wait_out(1'b0);
        lvl[0] <= 1'b0;
        wait_out(1'b1);
        // level before select, so the output never dips
        wr(8'h00, 32'h1480);
        wr(8'h00, 32'h1c80);
        wr(8'h00, 32'h1800);
        wait_out(1'b0);
        check("irq", 32'h01, irq);
        check("pin function", 0, pwake);
        rail <= 1'b0;
        wait_out(1'b1);
        settle(4);
        check("irq rail down", 0, irq);
        check("pin function", 1, pwake);
        rail <= 1'b1;
        wait_out(1'b0);
        wr(8'h00, 32'h1080);
        wait_out(1'b1);
        shut <= 1'b1;
        settle(2);
        shut <= 1'b0;
        settle(10);
        check("holdoff idle", 0, hold);
        wr(8'h10, 32'h01);
        rd(8'h10, 32'h01);
        shut <= 1'b1;
        n = 0;
        while (hold !== 1'b1 && n < 5) begin
            @(posedge clk_i);
            n++;
        end
        check("holdoff rise", 1, hold);
        shut <= 1'b0;
        week <= 1'b1;
        settle(4);
        check("held off", 0, out);
        rd(8'h00, 32'h13081);
        n = 0;
        while (hold !== 1'b0 && n < 20000) begin
            @(posedge clk_i);
            n++;
        end
        check("holdoff span", 1, n > ho_cyc - 40 && n < ho_cyc + 40);
        wait_out(1'b1);
        week <= 1'b0;
        sys_rst <= 1'b1;
        bus(1'b1, 8'h10, 32'h05);
        check("ack in system reset", 0, g);
        sys_rst <= 1'b0;
        rd(8'h10, 32'h01);
        report_and_stop();
    end
endmodule
